// File: src/adcs_defines.svh
// Register offsets, field positions, reset values and timing counts
`ifndef ADCS_DEFINES_SVH
`define ADCS_DEFINES_SVH

`define ADCS_ADDR_W 8
`define ADCS_OFF_CHEN 8'h24
`define ADCS_OFF_CMP0 8'h28
`define ADCS_OFF_CMP1 8'h2c
`define ADCS_OFF_STAT 8'h30
`define ADCS_OFF_CAL 8'h34

`define ADCS_CHEN_RST 10'h000
`define ADCS_CMP_RST 32'h00000000
`define ADCS_CMP_WMASK 32'h0fff0f3f
`define ADCS_CMP_VAL_HI 27
`define ADCS_CMP_VAL_LO 16
`define ADCS_CMP_CNT_HI 11
`define ADCS_CMP_CNT_LO 8
`define ADCS_CMP_CH_HI 5
`define ADCS_CMP_CH_LO 3
`define ADCS_CMP_COND 2
`define ADCS_CMP_IE 1
`define ADCS_CMP_EN 0

`define ADCS_ST_ADF 0
`define ADCS_ST_MONITOR0_FLAG 1
`define ADCS_ST_BUSY 3
`define ADCS_CAL_EN 0
`define ADCS_CAL_DONE 1

`define ADCS_BURST_EOC_LEVEL 5'h04
`define ADCS_CAL_ADC_CLOCKS 127
`define ADCS_CAL_CYCLES (`ADCS_CAL_ADC_CLOCKS)

`define ADCS_RESP_OKAY 2'h0
`define ADCS_RESP_SLVERR 2'h2

`endif

// File: src/adcs_pkg.sv
// Types shared by the converter control block
package adcs_pkg;
    // Operation mode, encodings in order 00..11
    typedef enum logic [1:0] {
        MODE_SINGLE,
        MODE_BURST,
        MODE_SCAN_ONCE,
        MODE_SCAN_CONT
    } adcs_mode_t;

    // Self-calibration sequence
    typedef enum logic [1:0] {
        CAL_IDLE,
        CAL_RUN,
        CAL_DONE
    } adcs_cal_state_t;
endpackage

// File: src/adcs_mon_if.sv
// Link between the register block and one result compare monitor
`timescale 1ns/1ps
`default_nettype none
interface adcs_mon_if;
    logic load;          // Result loaded this cycle
    logic [2:0] chan;    // Channel of the loaded result
    logic [11:0] result; // Loaded result
    logic [31:0] cfg;    // Monitor configuration word
    logic hit;           // Match count reached, one-cycle pulse

    modport ctl (output load, output chan, output result, output cfg, input hit);
    modport mon (input load, input chan, input result, input cfg, output hit);
endinterface
`default_nettype wire

// File: src/adcs_monitor.sv
// One result compare monitor with its match counter
`timescale 1ns/1ps
`default_nettype none
`include "adcs_defines.svh"
module adcs_monitor (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Configuration and results
    adcs_mon_if.mon mif
);
    logic [4:0] cnt_r;   // Consecutive matches, reaches 15 at most
    logic [4:0] target;  // Match count field plus one
    logic enabled;
    logic selected;
    logic meets;
    logic [4:0] cnt_inc;

    assign enabled = mif.cfg[`ADCS_CMP_EN];
    assign target = {1'b0, mif.cfg[`ADCS_CMP_CNT_HI:`ADCS_CMP_CNT_LO]} + 5'h01;
    assign selected = mif.load && enabled && (mif.chan == mif.cfg[`ADCS_CMP_CH_HI:`ADCS_CMP_CH_LO]);
    assign cnt_inc = cnt_r + 5'h01;

    // Condition bit chooses at-or-above versus strictly below
    always_comb begin
        if (mif.cfg[`ADCS_CMP_COND]) begin
            meets = mif.result >= mif.cfg[`ADCS_CMP_VAL_HI:`ADCS_CMP_VAL_LO];
        end else begin
            meets = mif.result < mif.cfg[`ADCS_CMP_VAL_HI:`ADCS_CMP_VAL_LO];
        end
    end

    // Match counter; restarts after a hit so the flag can fire again
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_r <= 5'h00;
        end else if (!enabled) begin
            cnt_r <= 5'h00;
        end else if (selected && !meets) begin
            cnt_r <= 5'h00;
        end else if (selected && (cnt_inc == target)) begin
            cnt_r <= 5'h00;
        end else if (selected) begin
            cnt_r <= cnt_inc;
        end
    end

    // Hit pulse, registered
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mif.hit <= 1'b0;
        end else begin
            mif.hit <= selected && meets && (cnt_inc == target);
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_counter_disabled: assert property (!enabled |=> cnt_r == 5'h00)
        else $error("match counter not cleared while disabled");
    chk_counter_miss: assert property (selected && !meets |=> cnt_r == 5'h00 && !mif.hit)
        else $error("match counter not cleared on a miss");
    chk_hit_count: assert property (mif.hit |-> $past(cnt_r) == $past(target) - 5'h01)
        else $error("hit without the programmed match count");
    cov_hit: cover property (mif.hit);
endmodule
`default_nettype wire

// File: src/adcs_top.sv
// Converter channel, compare and status registers behind an AXI4-Lite slave
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "adcs_defines.svh"
module adcs_top (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address and data
    input wire logic [`ADCS_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [`ADCS_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Conversion core status and events
    input wire logic result_load,
    input wire logic [2:0] result_chan,
    input wire logic [11:0] result_data,
    input wire logic [7:0] data_valid_flags,
    input wire logic [7:0] data_overrun_flags,
    input wire logic fifo_data_valid,
    input wire logic fifo_overrun,
    input wire logic [4:0] fifo_level,
    input wire logic single_conv_end,
    input wire logic scan_cycle_end,
    input wire logic [2:0] seq_chan,
    // Control bits held in the converter control register
    input wire logic conversion_start_bit,
    input wire logic [1:0] operation_mode_field,
    input wire logic converter_irq_enable,
    // Channel selection to the sequencer
    output logic [7:0] chan_enable_eff,
    output logic [2:0] single_chan,
    output logic [1:0] chan7_source_select,
    // Calibration
    output logic calibration_enable,
    output logic calibration_run,
    output logic calibration_done,
    // Interrupt requests
    output logic [1:0] compare_irq_request,
    output logic converter_irq_request
);
    adcs_pkg::adcs_mode_t mode;
    adcs_pkg::adcs_cal_state_t cal_st_r;
    logic [9:0] chen_r;         // Chan7_source_select 9:8, enables 7:0
    logic [31:0] cmp_r [2];     // Monitor configuration words
    logic adf_r;                // End-of-conversion flag
    logic [1:0] monitor_flag_r;         // Monitor flags
    logic calibration_enable_r;
    logic [7:0] cal_cnt_r;
    logic [`ADCS_ADDR_W-1:0] awaddr_r;
    logic aw_held_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic w_held_r;
    logic wr_go;                // Write performed this cycle
    logic [31:0] wmask;
    logic [31:0] wbits;         // Written bits under strobes
    logic [1:0] hit;
    logic [2:0] lowest;
    logic [7:0] vld_view;
    logic [7:0] ovr_view;
    logic [2:0] chan_view;
    logic [31:0] rd_word;
    logic rd_hit;
    logic wr_hit;
    logic adf_set;
    logic cal_go;

    assign mode = adcs_pkg::adcs_mode_t'(operation_mode_field);

    // Write channels taken in either order, held until the write is done
    assign s_axi_awready = !aw_held_r;
    assign s_axi_wready = !w_held_r;
    assign wr_go = aw_held_r && w_held_r && !s_axi_bvalid;
    assign wmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
    assign wbits = wdata_r & wmask;

    // Address capture
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            awaddr_r <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
        end else if (wr_go) begin
            aw_held_r <= 1'b0;
        end
    end

    // Data capture
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_r <= 1'b0;
            wdata_r <= 32'h00000000;
            wstrb_r <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
        end else if (wr_go) begin
            w_held_r <= 1'b0;
        end
    end

    // Decode of the held write address
    always_comb begin
        case (awaddr_r)
            `ADCS_OFF_CHEN, `ADCS_OFF_CMP0, `ADCS_OFF_CMP1, `ADCS_OFF_STAT, `ADCS_OFF_CAL: begin
                wr_hit = 1'b1;
            end
            default: begin
                wr_hit = 1'b0;
            end
        endcase
    end

    // Write response; unmapped addresses answer slave error
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `ADCS_RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? `ADCS_RESP_OKAY : `ADCS_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Channel enables and channel 7 source
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            chen_r <= `ADCS_CHEN_RST;
        end else if (wr_go && awaddr_r == `ADCS_OFF_CHEN) begin
            chen_r <= (chen_r & ~wmask[9:0]) | wbits[9:0];
        end
    end

    // Lowest enabled channel; channel 0 when nothing else is on
    always_comb begin
        lowest = 3'h0;
        for (int i = 7; i >= 1; i--) begin
            if (chen_r[i]) begin
                lowest = 3'(i);
            end
        end
        if (chen_r[0]) begin
            lowest = 3'h0;
        end
    end

    // Sequencer-facing selections, registered
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            chan_enable_eff <= 8'h01;
            single_chan <= 3'h0;
            chan7_source_select <= 2'h0;
        end else begin
            chan_enable_eff <= {chen_r[7:1], chen_r[0] | (chen_r[7:1] == 7'h00)};
            single_chan <= lowest;
            chan7_source_select <= chen_r[9:8];
        end
    end

    // Two monitors with their configuration words and flags
    for (genvar m = 0; m < 2; m++) begin : g_mon
        adcs_mon_if mif ();
        assign mif.load = result_load;
        assign mif.chan = result_chan;
        assign mif.result = result_data;
        assign mif.cfg = cmp_r[m];
        assign hit[m] = mif.hit;

        adcs_monitor u_mon (
            .aclk(aclk),
            .aresetn(aresetn),
            .mif(mif)
        );

        // Configuration; reserved bits never stored
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                cmp_r[m] <= `ADCS_CMP_RST;
            end else if (wr_go && awaddr_r == (m == 0 ? `ADCS_OFF_CMP0 : `ADCS_OFF_CMP1)) begin
                cmp_r[m] <= ((cmp_r[m] & ~wmask) | wbits) & `ADCS_CMP_WMASK;
            end
        end

        // Flag: a hit in the clearing cycle wins over the clear
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                monitor_flag_r[m] <= 1'b0;
            end else if (hit[m]) begin
                monitor_flag_r[m] <= 1'b1;
            end else if (wr_go && awaddr_r == `ADCS_OFF_STAT && wbits[`ADCS_ST_MONITOR0_FLAG + m]) begin
                monitor_flag_r[m] <= 1'b0;
            end
        end

        // Per-monitor compare request
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                compare_irq_request[m] <= 1'b0;
            end else begin
                compare_irq_request[m] <= monitor_flag_r[m] && cmp_r[m][`ADCS_CMP_IE];
            end
        end
    end

    // End-of-conversion sources depend on the mode
    always_comb begin
        case (mode)
            adcs_pkg::MODE_SINGLE: begin
                adf_set = single_conv_end;
            end
            adcs_pkg::MODE_BURST: begin
                adf_set = fifo_level > `ADCS_BURST_EOC_LEVEL;
            end
            adcs_pkg::MODE_SCAN_ONCE, adcs_pkg::MODE_SCAN_CONT: begin
                adf_set = scan_cycle_end;
            end
            default: begin
                adf_set = 1'b0;
            end
        endcase
    end

    // End flag; set wins over a clear in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            adf_r <= 1'b0;
        end else if (adf_set) begin
            adf_r <= 1'b1;
        end else if (wr_go && awaddr_r == `ADCS_OFF_STAT && wbits[`ADCS_ST_ADF]) begin
            adf_r <= 1'b0;
        end
    end

    // Combined converter request covers the end flag and both monitors
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            converter_irq_request <= 1'b0;
        end else begin
            converter_irq_request <= (adf_r && converter_irq_enable)
                || (monitor_flag_r[0] && cmp_r[0][`ADCS_CMP_IE])
                || (monitor_flag_r[1] && cmp_r[1][`ADCS_CMP_IE]);
        end
    end

    // Calibration enable register; a rising write starts the sequence
    assign cal_go = wr_go && awaddr_r == `ADCS_OFF_CAL && wstrb_r[0]
        && wdata_r[`ADCS_CAL_EN] && !calibration_enable_r;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            calibration_enable_r <= 1'b0;
        end else if (wr_go && awaddr_r == `ADCS_OFF_CAL && wstrb_r[0]) begin
            calibration_enable_r <= wdata_r[`ADCS_CAL_EN];
        end
    end

    // Calibration sequencer; dropping enable aborts and clears done
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cal_st_r <= adcs_pkg::CAL_IDLE;
            cal_cnt_r <= 8'h00;
        end else if (wr_go && awaddr_r == `ADCS_OFF_CAL && wstrb_r[0] && !wdata_r[`ADCS_CAL_EN]) begin
            cal_st_r <= adcs_pkg::CAL_IDLE;
            cal_cnt_r <= 8'h00;
        end else begin
            case (cal_st_r)
                adcs_pkg::CAL_IDLE: begin
                    if (cal_go) begin
                        cal_st_r <= adcs_pkg::CAL_RUN;
                        cal_cnt_r <= 8'h00;
                    end
                end
                adcs_pkg::CAL_RUN: begin
                    if (cal_cnt_r == 8'(`ADCS_CAL_CYCLES - 1)) begin
                        cal_st_r <= adcs_pkg::CAL_DONE;
                    end
                    cal_cnt_r <= cal_cnt_r + 8'h01;
                end
                adcs_pkg::CAL_DONE: begin
                    cal_st_r <= adcs_pkg::CAL_DONE;
                end
                default: begin
                    cal_st_r <= adcs_pkg::CAL_IDLE;
                end
            endcase
        end
    end

    assign calibration_enable = calibration_enable_r;
    assign calibration_run = cal_st_r == adcs_pkg::CAL_RUN;
    assign calibration_done = cal_st_r == adcs_pkg::CAL_DONE;

    // Status views; burst mode spreads the FIFO flags over all bits
    assign vld_view = (mode == adcs_pkg::MODE_BURST) ? {8{fifo_data_valid}} : data_valid_flags;
    assign ovr_view = (mode == adcs_pkg::MODE_BURST) ? {8{fifo_overrun}} : data_overrun_flags;
    // Idle single mode shows the lowest enabled channel as next
    assign chan_view = (!conversion_start_bit && mode == adcs_pkg::MODE_SINGLE) ? lowest : seq_chan;

    // Read word assembly; reserved bits read zero
    always_comb begin
        rd_hit = 1'b1;
        case (s_axi_araddr)
            `ADCS_OFF_CHEN: begin
                rd_word = {22'h000000, chen_r};
            end
            `ADCS_OFF_CMP0: begin
                rd_word = cmp_r[0];
            end
            `ADCS_OFF_CMP1: begin
                rd_word = cmp_r[1];
            end
            `ADCS_OFF_STAT: begin
                rd_word = {8'h00, ovr_view, vld_view, 1'b0, chan_view,
                    conversion_start_bit, monitor_flag_r, adf_r};
            end
            `ADCS_OFF_CAL: begin
                rd_word = {30'h00000000, calibration_done, calibration_enable_r};
            end
            default: begin
                rd_word = 32'h00000000;
                rd_hit = 1'b0;
            end
        endcase
    end

    // Read channel: answer one cycle after the address is taken
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `ADCS_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_hit ? `ADCS_RESP_OKAY : `ADCS_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_chan0_default: assert property ($past(chen_r[7:1]) == 7'h00 |-> chan_enable_eff[0])
        else $error("channel 0 not enabled by default");
    chk_lowest_chan: assert property (chen_r[2:0] == 3'h4 ##1 chen_r[2:0] == 3'h4 |-> single_chan == 3'h2)
        else $error("single mode channel is not the lowest");
    chk_monitor_flag_set: assert property (hit[1] |=> monitor_flag_r[1] ##1 monitor_flag_r[1] || $past(wr_go))
        else $error("monitor flag not set by a hit");
    chk_adf_sticky: assert property (adf_r && !(wr_go && awaddr_r == `ADCS_OFF_STAT) |=> adf_r)
        else $error("end flag dropped without a clearing write");
    chk_adf_single: assert property (mode == adcs_pkg::MODE_SINGLE && single_conv_end |=> adf_r)
        else $error("single conversion end did not set the end flag");
    chk_conv_irq: assert property (adf_r && converter_irq_enable |=> converter_irq_request)
        else $error("converter request missing");
    chk_cmp_irq: assert property (monitor_flag_r[0] && cmp_r[0][`ADCS_CMP_IE] |=> compare_irq_request[0])
        else $error("compare request missing");
    chk_cal_time: assert property (cal_go |=> calibration_run [*8] ##120 (calibration_done || !calibration_enable_r))
        else $error("calibration did not finish after 127 clocks");
    chk_cal_clear: assert property (wr_go && awaddr_r == `ADCS_OFF_CAL && wstrb_r[0] && !wdata_r[0]
        |=> !calibration_done)
        else $error("calibration done not cleared");
    chk_burst_mirror: assert property (mode == adcs_pkg::MODE_BURST && fifo_overrun |-> ovr_view == 8'hff)
        else $error("burst overrun not spread");
    chk_resp_follows: assert property (wr_go |=> s_axi_bvalid && !aw_held_r && !w_held_r)
        else $error("write response missing");
    cov_cal_done: cover property (calibration_done);
    cov_adf_clear: cover property (adf_r ##1 !adf_r);
    cov_rd_status: cover property (s_axi_arvalid && s_axi_arready && s_axi_araddr == `ADCS_OFF_STAT);
endmodule
`default_nettype wire

// File: dv/adcs_core_model.sv
// Behavioural model of the conversion core and its sequencer
`timescale 1ns/1ps
`default_nettype none
module adcs_core_model (
    // Clock
    input wire logic aclk,
    // Results and status towards the controller
    output logic result_load,
    output logic [2:0] result_chan,
    output logic [11:0] result_data,
    output logic [7:0] data_valid_flags,
    output logic [7:0] data_overrun_flags,
    output logic fifo_data_valid,
    output logic fifo_overrun,
    output logic [4:0] fifo_level,
    output logic single_conv_end,
    output logic scan_cycle_end,
    output logic [2:0] seq_chan
);
    // Quiet core at time zero; mirrors are set by the bench
    initial begin
        {result_load, result_chan, result_data, fifo_data_valid, fifo_overrun} = '0;
        {data_valid_flags, data_overrun_flags, fifo_level, single_conv_end} = '0;
        {scan_cycle_end, seq_chan} = '0;
    end
    // One result per load pulse; stale data inverted so it never matches by chance
    task automatic load(input logic [2:0] ch, input logic [11:0] d);
        @(posedge aclk);
        result_load <= 1'b1;
        result_chan <= ch;
        result_data <= d;
        @(posedge aclk);
        result_load <= 1'b0;
        result_data <= ~d;
    endtask
    // One-cycle end pulse, single or scan
    task automatic pulse(input logic scan);
        @(posedge aclk);
        single_conv_end <= !scan;
        scan_cycle_end <= scan;
        @(posedge aclk);
        {single_conv_end, scan_cycle_end} <= 2'b00;
    endtask
endmodule
`default_nettype wire

// File: dv/testbench.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
`include "adcs_defines.svh"
module testbench;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, result_load;
    logic fifo_data_valid, fifo_overrun, single_conv_end, scan_cycle_end, conversion_start_bit;
    logic converter_irq_enable, calibration_enable, calibration_run, calibration_done;
    logic converter_irq_request;
    logic [7:0] s_axi_awaddr, s_axi_araddr, data_valid_flags, data_overrun_flags, chan_enable_eff;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, operation_mode_field, chan7_source_select;
    logic [1:0] compare_irq_request, rs;
    logic [11:0] result_data;
    logic [4:0] fifo_level;
    logic [2:0] result_chan, seq_chan, single_chan;
    int fail_count = 0, check_count = 0, run_cnt = 0;
    adcs_top dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .result_load, .result_chan, .result_data, .data_valid_flags,
        .data_overrun_flags, .fifo_data_valid, .fifo_overrun, .fifo_level, .single_conv_end,
        .scan_cycle_end, .seq_chan, .conversion_start_bit, .operation_mode_field,
        .converter_irq_enable, .chan_enable_eff, .single_chan, .chan7_source_select,
        .calibration_enable, .calibration_run, .calibration_done, .compare_irq_request,
        .converter_irq_request);
    adcs_core_model core_u (.aclk, .result_load, .result_chan, .result_data, .data_valid_flags,
        .data_overrun_flags, .fifo_data_valid, .fifo_overrun, .fifo_level, .single_conv_end,
        .scan_cycle_end, .seq_chan);
    // Clock, 5 ns period
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    // Calibration run length, counted independently of the design
    always @(posedge aclk) if (calibration_run === 1'b1) run_cnt <= run_cnt + 1;
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // Bounded wait ran out
    task automatic tmo(input int n);
        if (n >= 300) begin
            fail_count++;
            finish_test();
        end
    endtask
    // Write: address and data offered together, each released once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        logic aw, w, b;
        n = 0;
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'b111};
        do begin
            @(negedge aclk);
            aw = s_axi_awvalid & s_axi_awready;
            w = s_axi_wvalid & s_axi_wready;
            b = s_axi_bvalid;
            rs = s_axi_bresp;
            @(posedge aclk);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
            n++;
        end while (b !== 1'b1 && n < 300);
        s_axi_bready <= 1'b0;
        tmo(n);
        chk(rs, er);
    endtask
    // Read: request held until taken, rready held until data arrives
    task automatic rdw(input logic [7:0] a, input logic [1:0] er);
        int n;
        logic ar, r;
        n = 0;
        @(posedge aclk);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
        do begin
            @(negedge aclk);
            ar = s_axi_arvalid & s_axi_arready;
            r = s_axi_rvalid;
            {rd, rs} = {s_axi_rdata, s_axi_rresp};
            @(posedge aclk);
            if (ar) s_axi_arvalid <= 1'b0;
            n++;
        end while (r !== 1'b1 && n < 300);
        s_axi_rready <= 1'b0;
        tmo(n);
        chk(rs, er);
    endtask
    task automatic t_regs();
        rdw(8'h28, 2'h0);
        chk(rd, 32'h0);
        rdw(8'h34, 2'h0);
        chk(rd, 32'h0);
        chk(chan_enable_eff, 8'h01);
        rdw(8'h38, 2'h2);
        wr(8'h38, 32'h1, 2'h2);
        wr(8'h24, 32'h0000012c, 2'h0);
        rdw(8'h24, 2'h0);
        chk(rd, 32'h0000012c);
        chk({chan7_source_select, single_chan, chan_enable_eff}, {2'h1, 3'h2, 8'h2c});
        $display("registers done");
    endtask
    task automatic t_mon();
        wr(8'h28, 32'h0100011f, 2'h0);
        core_u.load(3'h3, 12'h100);
        core_u.load(3'h3, 12'h0ff);
        core_u.load(3'h3, 12'h200);
        core_u.load(3'h2, 12'h300);
        rdw(8'h30, 2'h0);
        chk(rd[2:1], 2'b00);
        core_u.load(3'h3, 12'h100);
        repeat (3) @(posedge aclk);
        rdw(8'h30, 2'h0);
        chk({rd[2:1], compare_irq_request}, 4'b0101);
        wr(8'h30, 32'h2, 2'h0);
        core_u.load(3'h3, 12'h100);
        wr(8'h28, 32'h0100011e, 2'h0);
        core_u.load(3'h3, 12'h100);
        wr(8'h28, 32'h0100011f, 2'h0);
        core_u.load(3'h3, 12'h100);
        wr(8'h2c, 32'h00800039, 2'h0);
        core_u.load(3'h7, 12'h080);
        repeat (3) @(posedge aclk);
        rdw(8'h30, 2'h0);
        chk({rd[2:1], compare_irq_request}, 4'b0000);
        core_u.load(3'h7, 12'h07f);
        repeat (3) @(posedge aclk);
        rdw(8'h30, 2'h0);
        chk(rd[2:1], 2'b10);
        wr(8'h30, 32'h4, 2'h0);
        rdw(8'h30, 2'h0);
        chk(rd[2:1], 2'b00);
        $display("monitors done");
    endtask
    task automatic t_stat();
        converter_irq_enable <= 1'b1;
        for (int m = 0; m < 4; m++) begin
            operation_mode_field <= m[1:0];
            core_u.fifo_level <= 5'h4;
            if (m != 1) core_u.pulse(m[1]);
            rdw(8'h30, 2'h0);
            chk(rd[0], m != 1);
            core_u.fifo_level <= 5'h5;
            repeat (3) @(posedge aclk);
            core_u.fifo_level <= 5'h0;
            wr(8'h30, 32'h0, 2'h0);
            rdw(8'h30, 2'h0);
            chk({rd[0], converter_irq_request}, 2'b11);
            wr(8'h30, 32'h1, 2'h0);
            rdw(8'h30, 2'h0);
            chk({rd[0], converter_irq_request}, 2'b00);
        end
        {operation_mode_field, core_u.fifo_data_valid, core_u.fifo_overrun} <= 4'b0111;
        rdw(8'h30, 2'h0);
        chk(rd[23:8], 16'hffff);
        operation_mode_field <= 2'h0;
        {core_u.data_valid_flags, core_u.data_overrun_flags} <= 16'h5a3c;
        rdw(8'h30, 2'h0);
        chk(rd, 32'h003c5a20);
        conversion_start_bit <= 1'b1;
        core_u.seq_chan <= 3'h6;
        rdw(8'h30, 2'h0);
        chk(rd, 32'h003c5a68);
        $display("status done");
    endtask
    task automatic t_cal();
        int n;
        wr(8'h34, 32'h1, 2'h0);
        for (n = 0; n < 300 && calibration_done !== 1'b1; n++) @(negedge aclk);
        tmo(n);
        chk(run_cnt, 127);
        rdw(8'h34, 2'h0);
        chk(rd, 32'h3);
        wr(8'h34, 32'h0, 2'h0);
        chk({calibration_done, calibration_enable}, 2'b00);
        $display("calibration done");
    endtask
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, conversion_start_bit} = '0;
        {operation_mode_field, converter_irq_enable} = '0;
        s_axi_wstrb = 4'hf;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_mon();
        t_stat();
        t_cal();
        finish_test();
    end
endmodule
`default_nettype wire
